// >>> logic/speed_aux.sv
// Purpose: Speed-mode auxiliary logic: torque limits, command shaping,
//          speed status flags and speed filtering.
// Assumes: One control tick per clock; AHB-Lite slave for parameters.
// Notes:   Speeds are signed 16-bit rpm; limits are tenths of a percent.
`timescale 1ns/1ns
`default_nettype none
module speed_aux
    import speed_aux_pkg::*;
#(
    parameter int SPD_W = 16
)(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic [15:0]             analog_in_1,
    input  wire logic [15:0]             analog_in_2,
    input  wire logic [15:0]             analog_in_3,
    input  wire logic signed [SPD_W-1:0] speed_cmd_in,
    input  wire logic signed [SPD_W-1:0] speed_feedback,
    input  wire logic                    pos_speed_limit_select_b,
    input  wire logic                    neg_speed_limit_select_b,
    input  wire logic                    jog_forward_in,
    input  wire logic                    jog_reverse_in,
    input  wire logic                    command_invert_in,
    input  wire logic                    speed_hold_in,
    input  wire logic                    lock_enable_in,
    output logic signed [SPD_W-1:0]      speed_cmd_out,
    output logic                         lock_active,
    output logic      [15:0]             fwd_torque_limit,
    output logic      [15:0]             rev_torque_limit,
    output logic                         pos_speed_use_b,
    output logic                         neg_speed_use_b,
    output logic                         coincidence_flag,
    output logic                         arrival_flag,
    output logic                         standstill_flag,
    output logic                         speeding_flag,
    output logic                         slowing_flag,
    output logic                         fwd_rotation_flag,
    output logic                         rev_rotation_flag
);
    import speed_aux_pkg::*;

    function automatic logic [15:0] clamp_limit(input logic [15:0] v);
        clamp_limit = (v > LIMIT_MAX) ? LIMIT_MAX : v;
    endfunction

    function automatic logic [15:0] pick_src(input logic [1:0] s, input logic [15:0] set_v,
                                             input logic [15:0] a1, input logic [15:0] a2,
                                             input logic [15:0] a3);
        unique case (s)
            SRC_SET:  pick_src = clamp_limit(set_v);
            SRC_AIN1: pick_src = clamp_limit(a1);
            SRC_AIN2: pick_src = clamp_limit(a2);
            default:  pick_src = clamp_limit(a3);
        endcase
    endfunction

    function automatic logic [15:0] pick_limit(input logic [1:0] s, input logic [15:0] a,
                                               input logic [15:0] b, input logic sw);
        unique case (s)
            SEL_A:      pick_limit = a;
            SEL_B:      pick_limit = b;
            SEL_SWITCH: pick_limit = sw ? b : a;
            default:    pick_limit = (a < b) ? a : b;
        endcase
    endfunction

    function automatic logic signed [SPD_W:0] mag(input logic signed [SPD_W:0] v);
        mag = (v < 0) ? -v : v;
    endfunction

    // Filter shift from a time constant: roughly log2 of the ms figure.
    function automatic logic [3:0] tc_shift(input logic [15:0] t);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 16; i++)
            if (t[i])
                s = i[3:0];
        tc_shift = (s > FILT_SHIFT_MAX) ? FILT_SHIFT_MAX : s;
    endfunction

    logic [15:0] tq_method, pos_tq_sel, fwd_a_src, fwd_a_val, fwd_b_src, fwd_b_val;
    logic [15:0] rev_tq_sel, rev_a_src, rev_a_val, rev_b_src, rev_b_val;
    logic [15:0] lock_thr, jog_speed, arr_thr, coin_thr, zero_thr, acc_thr;
    logic [15:0] fb_filt_time, disp_filt_time;
    logic [3:0]  fb_shift;

    // Bus address phase capture.
    logic        dp_write;
    logic        dp_read;
    logic [11:0] dp_addr;
    wire  logic  ap_valid = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 12'h000;
        end
        else
        begin
            dp_write <= ap_valid & hwrite;
            dp_read  <= ap_valid & ~hwrite;
            dp_addr  <= (ap_valid) ? haddr[11:0] : dp_addr;
        end
    end

    // Parameter registers; writes act on the tick after the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tq_method <= 16'h0000; pos_tq_sel <= 16'h0000; rev_tq_sel <= 16'h0000;
            fwd_a_src <= 16'h0000; fwd_b_src <= 16'h0000;
            rev_a_src <= 16'h0000; rev_b_src <= 16'h0000;
            fwd_a_val <= RST_LIMIT_VAL; fwd_b_val <= RST_LIMIT_VAL;
            rev_a_val <= RST_LIMIT_VAL; rev_b_val <= RST_LIMIT_VAL;
            lock_thr  <= RST_LOCK_THR;  jog_speed <= RST_JOG_SPEED;
            arr_thr   <= RST_ARR_THR;   coin_thr  <= RST_COIN_THR;
            zero_thr  <= RST_ZERO_THR;  acc_thr   <= RST_ACC_THR;
            fb_filt_time <= RST_FB_FILT; disp_filt_time <= RST_DISP_FILT;
        end
        else if (dp_write)
        begin
            unique case (dp_addr)
                OFS_TQ_METHOD:  tq_method  <= {15'h0000, hwdata[0]};
                OFS_POS_TQ_SEL: pos_tq_sel <= {14'h0000, hwdata[1:0]};
                OFS_FWD_A_SRC:  fwd_a_src  <= {14'h0000, hwdata[1:0]};
                OFS_FWD_A_VAL:  fwd_a_val  <= clamp_limit(hwdata[15:0]);
                OFS_FWD_B_SRC:  fwd_b_src  <= {14'h0000, hwdata[1:0]};
                OFS_FWD_B_VAL:  fwd_b_val  <= clamp_limit(hwdata[15:0]);
                OFS_REV_TQ_SEL: rev_tq_sel <= {14'h0000, hwdata[1:0]};
                OFS_REV_A_SRC:  rev_a_src  <= {14'h0000, hwdata[1:0]};
                OFS_REV_A_VAL:  rev_a_val  <= clamp_limit(hwdata[15:0]);
                OFS_REV_B_SRC:  rev_b_src  <= {14'h0000, hwdata[1:0]};
                OFS_REV_B_VAL:  rev_b_val  <= clamp_limit(hwdata[15:0]);
                OFS_LOCK_THR:   lock_thr   <= {1'b0, hwdata[14:0]};
                OFS_JOG_SPEED:  jog_speed  <= {1'b0, hwdata[14:0]};
                OFS_ARR_THR:    arr_thr    <= {1'b0, hwdata[14:0]};
                OFS_COIN_THR:   coin_thr   <= {1'b0, hwdata[14:0]};
                OFS_ZERO_THR:   zero_thr   <= {1'b0, hwdata[14:0]};
                OFS_ACC_THR:    acc_thr    <= {1'b0, hwdata[14:0]};
                OFS_FB_FILT:    fb_filt_time   <= {1'b0, hwdata[14:0]};
                OFS_DISP_FILT:  disp_filt_time <= {1'b0, hwdata[14:0]};
                default: ;
            endcase
        end
    end

    // The feedback filter shift latches from fb_filt_time on the first tick after reset, then holds while nonzero.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fb_shift <= 4'h0;
        else if (fb_shift == 4'h0)
            fb_shift <= tc_shift(fb_filt_time);
    end

    // Torque limits.
    logic [15:0] fa, fb, ra, rb, fwd_lim, rev_lim;
    always_comb
    begin
        fa = pick_src(fwd_a_src[1:0], fwd_a_val, analog_in_1, analog_in_2, analog_in_3);
        fb = pick_src(fwd_b_src[1:0], fwd_b_val, analog_in_1, analog_in_2, analog_in_3);
        ra = pick_src(rev_a_src[1:0], rev_a_val, analog_in_1, analog_in_2, analog_in_3);
        rb = pick_src(rev_b_src[1:0], rev_b_val, analog_in_1, analog_in_2, analog_in_3);
        fwd_lim = pick_limit(pos_tq_sel[1:0], fa, fb, pos_speed_limit_select_b);
        rev_lim = pick_limit(rev_tq_sel[1:0], ra, rb, neg_speed_limit_select_b);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fwd_torque_limit <= 16'h0000;
            rev_torque_limit <= 16'h0000;
            pos_speed_use_b  <= 1'b0;
            neg_speed_use_b  <= 1'b0;
        end
        else
        begin
            fwd_torque_limit <= fwd_lim;
            rev_torque_limit <= tq_method[0] ? rev_lim : fwd_lim;
            pos_speed_use_b  <= pos_speed_limit_select_b;
            neg_speed_use_b  <= neg_speed_limit_select_b;
        end
    end

    // Command shaping: invert, jog, hold, then lock.
    logic signed [SPD_W:0] cmd_inv, cmd_jog, cmd_mag;
    lock_state_t lock_state, next_lock_state;
    always_comb
    begin
        cmd_inv = $signed({speed_cmd_in[SPD_W-1], speed_cmd_in});
        if (command_invert_in)
            cmd_inv = -cmd_inv;
        cmd_jog = cmd_inv;
        if (jog_forward_in && !jog_reverse_in)
            cmd_jog = cmd_inv + $signed({1'b0, jog_speed});
        else if (jog_reverse_in && !jog_forward_in)
            cmd_jog = cmd_inv - $signed({1'b0, jog_speed});
        if (speed_hold_in)
            cmd_jog = '0;
        cmd_mag = mag(cmd_jog);
        unique case (lock_state)
            RUN_FOLLOW: next_lock_state = (lock_enable_in && cmd_mag <= $signed({1'b0, lock_thr}))
                                          ? RUN_LOCKED : RUN_FOLLOW;
            RUN_LOCKED: next_lock_state = (!lock_enable_in || cmd_mag > $signed({1'b0, lock_thr}))
                                          ? RUN_FOLLOW : RUN_LOCKED;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_state    <= RUN_FOLLOW;
            lock_active   <= 1'b0;
            speed_cmd_out <= '0;
        end
        else
        begin
            lock_state    <= next_lock_state;
            lock_active   <= (next_lock_state == RUN_LOCKED);
            // Locked: the speed command is dropped and the position loop holds.
            speed_cmd_out <= (next_lock_state == RUN_LOCKED) ? '0 : cmd_jog[SPD_W-1:0];
        end
    end

    // First-order filters: y += (x - y) >> shift.
    logic signed [SPD_W+15:0] fb_acc, disp_acc;
    logic signed [SPD_W-1:0]  filt_speed, disp_speed, prev_speed;
    logic [3:0] disp_shift;
    assign disp_shift = tc_shift(disp_filt_time);
    assign filt_speed = fb_acc[SPD_W+15:16];
    assign disp_speed = disp_acc[SPD_W+15:16];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fb_acc     <= '0;
            disp_acc   <= '0;
            prev_speed <= '0;
        end
        else
        begin
            fb_acc   <= fb_acc + ((($signed({speed_feedback, 16'h0000})) - fb_acc) >>> fb_shift);
            disp_acc <= disp_acc + ((($signed({filt_speed, 16'h0000})) - disp_acc) >>> disp_shift);
            prev_speed <= filt_speed;
        end
    end

    // Status flags, refreshed every tick.
    logic signed [SPD_W:0] fs, gap, accel;
    always_comb
    begin
        fs    = $signed({filt_speed[SPD_W-1], filt_speed});
        gap   = fs - $signed({speed_cmd_out[SPD_W-1], speed_cmd_out});
        accel = fs - $signed({prev_speed[SPD_W-1], prev_speed});
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            coincidence_flag  <= 1'b0;
            arrival_flag      <= 1'b0;
            standstill_flag   <= 1'b0;
            speeding_flag     <= 1'b0;
            slowing_flag      <= 1'b0;
            fwd_rotation_flag <= 1'b0;
            rev_rotation_flag <= 1'b0;
        end
        else
        begin
            coincidence_flag  <= mag(gap) <= $signed({1'b0, coin_thr});
            arrival_flag      <= mag(fs) > $signed({1'b0, arr_thr});
            standstill_flag   <= mag(fs) < $signed({1'b0, zero_thr});
            speeding_flag     <= (mag(fs) > mag(fs - accel)) &&
                                 mag(accel) > $signed({1'b0, acc_thr});
            slowing_flag      <= (mag(fs) < mag(fs - accel)) &&
                                 mag(accel) > $signed({1'b0, acc_thr});
            fwd_rotation_flag <= fs > $signed({1'b0, zero_thr});
            rev_rotation_flag <= fs < -$signed({1'b0, zero_thr});
        end
    end

    // Read mux and bus response; one wait state on reads, none on writes.
    logic [15:0] rd;
    always_comb
    begin
        unique case (dp_addr)
            OFS_TQ_METHOD:  rd = tq_method;
            OFS_POS_TQ_SEL: rd = pos_tq_sel;
            OFS_FWD_A_SRC:  rd = fwd_a_src;
            OFS_FWD_A_VAL:  rd = fwd_a_val;
            OFS_FWD_B_SRC:  rd = fwd_b_src;
            OFS_FWD_B_VAL:  rd = fwd_b_val;
            OFS_REV_TQ_SEL: rd = rev_tq_sel;
            OFS_REV_A_SRC:  rd = rev_a_src;
            OFS_REV_A_VAL:  rd = rev_a_val;
            OFS_REV_B_SRC:  rd = rev_b_src;
            OFS_REV_B_VAL:  rd = rev_b_val;
            OFS_LOCK_THR:   rd = lock_thr;
            OFS_JOG_SPEED:  rd = jog_speed;
            OFS_ARR_THR:    rd = arr_thr;
            OFS_COIN_THR:   rd = coin_thr;
            OFS_ZERO_THR:   rd = zero_thr;
            OFS_ACC_THR:    rd = acc_thr;
            OFS_FB_FILT:    rd = fb_filt_time;
            OFS_DISP_FILT:  rd = disp_filt_time;
            OFS_FILT_SPEED: rd = 16'(filt_speed);
            OFS_DISP_SPEED: rd = 16'(disp_speed);
            OFS_STATUS:     rd = {8'h00, lock_active, rev_rotation_flag, fwd_rotation_flag,
                                  slowing_flag, speeding_flag, standstill_flag,
                                  arrival_flag, coincidence_flag};
            default:        rd = 16'h0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (ap_valid && !hwrite)
            hrdata <= 32'h0000_0000;
        else if (dp_read)
            hrdata <= {16'h0000, rd};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= !(ap_valid && !hwrite);
            hresp     <= 1'b0;
        end
    end

    // Assertions.
    a_hold_zero_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
        speed_hold_in |=> speed_cmd_out == '0) else $error("hold did not zero command");
    a_lock_needs_en: assert property (@(posedge hclk) disable iff (!hresetn)
        !lock_enable_in |=> !lock_active) else $error("locked without enable");
    a_lock_enter: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_enable_in && speed_hold_in |=> lock_active) else $error("lock not entered");
    a_lock_exit: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_enable_in && !speed_hold_in && cmd_mag > $signed({1'b0, lock_thr})
        |=> !lock_active) else $error("lock not left");
    a_method_shared: assert property (@(posedge hclk) disable iff (!hresetn)
        !tq_method[0] |=> rev_torque_limit == $past(fwd_lim)) else $error("method 0 broken");
    a_limit_ceiling: assert property (@(posedge hclk) disable iff (!hresetn)
        fwd_torque_limit <= LIMIT_MAX && rev_torque_limit <= LIMIT_MAX)
        else $error("limit above ceiling");
    a_both_min: assert property (@(posedge hclk) disable iff (!hresetn)
        pos_tq_sel[1:0] == SEL_BOTH |=> fwd_torque_limit <= $past(fa) && fwd_torque_limit <= $past(fb))
        else $error("both did not take minimum");
    a_rot_exclusive: assert property (@(posedge hclk) disable iff (!hresetn)
        !(fwd_rotation_flag && rev_rotation_flag)) else $error("both rotations flagged");
    a_zero_rot: assert property (@(posedge hclk) disable iff (!hresetn)
        standstill_flag |-> !fwd_rotation_flag && !rev_rotation_flag)
        else $error("standstill with rotation");
endmodule // speed_aux
`default_nettype wire

// >>> logic/speed_aux_pkg.sv
// Purpose: Shared constants for the speed-mode auxiliary block.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes:   Offsets are byte addresses.
package speed_aux_pkg;
    localparam int DW = 16;
    localparam logic [11:0] OFS_TQ_METHOD  = 12'h000;
    localparam logic [11:0] OFS_POS_TQ_SEL = 12'h004;
    localparam logic [11:0] OFS_FWD_A_SRC  = 12'h008;
    localparam logic [11:0] OFS_FWD_A_VAL  = 12'h00c;
    localparam logic [11:0] OFS_FWD_B_SRC  = 12'h010;
    localparam logic [11:0] OFS_FWD_B_VAL  = 12'h014;
    localparam logic [11:0] OFS_REV_TQ_SEL = 12'h018;
    localparam logic [11:0] OFS_REV_A_SRC  = 12'h01c;
    localparam logic [11:0] OFS_REV_A_VAL  = 12'h020;
    localparam logic [11:0] OFS_REV_B_SRC  = 12'h024;
    localparam logic [11:0] OFS_REV_B_VAL  = 12'h028;
    localparam logic [11:0] OFS_LOCK_THR   = 12'h02c;
    localparam logic [11:0] OFS_JOG_SPEED  = 12'h030;
    localparam logic [11:0] OFS_ARR_THR    = 12'h034;
    localparam logic [11:0] OFS_COIN_THR   = 12'h038;
    localparam logic [11:0] OFS_ZERO_THR   = 12'h03c;
    localparam logic [11:0] OFS_ACC_THR    = 12'h040;
    localparam logic [11:0] OFS_FB_FILT    = 12'h044;
    localparam logic [11:0] OFS_DISP_FILT  = 12'h048;
    localparam logic [11:0] OFS_FILT_SPEED = 12'h04c;
    localparam logic [11:0] OFS_DISP_SPEED = 12'h050;
    localparam logic [11:0] OFS_STATUS     = 12'h054;
    localparam logic [15:0] RST_LIMIT_VAL  = 16'h05dc;
    localparam logic [15:0] RST_LOCK_THR   = 16'h0005;
    localparam logic [15:0] RST_JOG_SPEED  = 16'h0014;
    localparam logic [15:0] RST_ARR_THR    = 16'h03e8;
    localparam logic [15:0] RST_COIN_THR   = 16'h000a;
    localparam logic [15:0] RST_ZERO_THR   = 16'h0005;
    localparam logic [15:0] RST_ACC_THR    = 16'h0177;
    localparam logic [15:0] RST_FB_FILT    = 16'h0005;
    localparam logic [15:0] RST_DISP_FILT  = 16'h012c;
    localparam logic [15:0] LIMIT_MAX      = 16'h0bb8;
    localparam logic [3:0]  FILT_SHIFT_MAX = 4'hf;
    localparam logic [1:0]  SEL_A          = 2'h0;
    localparam logic [1:0]  SEL_B          = 2'h1;
    localparam logic [1:0]  SEL_SWITCH     = 2'h2;
    localparam logic [1:0]  SEL_BOTH       = 2'h3;
    localparam logic [1:0]  SRC_SET        = 2'h0;
    localparam logic [1:0]  SRC_AIN1       = 2'h1;
    localparam logic [1:0]  SRC_AIN2       = 2'h2;
    localparam logic [1:0]  SRC_AIN3       = 2'h3;
    localparam int ST_COIN = 0;
    localparam int ST_ARR  = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_UP   = 3;
    localparam int ST_DOWN = 4;
    localparam int ST_FWD  = 5;
    localparam int ST_REV  = 6;
    localparam int ST_LOCK = 7;
    typedef enum logic [1:0] {
        RUN_FOLLOW = 2'b01,
        RUN_LOCKED = 2'b10
    } lock_state_t;
endpackage

// >>> test/motion_ctrl_model.sv
// Purpose: Stand-in for the motion controller on the command side.
// Assumes: The bench posts requests; the model applies them on a rising edge.
// Notes:   Registered outputs, so inputs never change on a sampling race.
`timescale 1ns/1ns
`default_nettype none
module motion_ctrl_model (
    input  wire logic              hclk,
    input  wire logic [6:0]        req_bits,
    input  wire logic signed [15:0] req_cmd,
    input  wire logic signed [15:0] req_fb,
    output logic      [6:0]        bits = 7'h0,
    output logic signed [15:0]     cmd = 16'sh0,
    output logic signed [15:0]     fb = 16'sh0
);
    always @(posedge hclk)
    begin
        bits <= req_bits;
        cmd  <= req_cmd;
        fb   <= req_fb;
    end
endmodule // motion_ctrl_model
`default_nettype wire

// >>> test/tb_servo_speed_mode_aux.sv
// Purpose: Self-checking bench for the speed-mode auxiliary block.
// Assumes: Registers are reached over AHB-Lite, one aligned word each.
// Notes:   Drivers queue expectations; a monitor compares them in order.
`timescale 1ns/1ns
`default_nettype none
module tb_servo_speed_mode_aux;
    import speed_aux_pkg::*;
    typedef struct packed { logic [3:0] sel; logic [31:0] v; } note_t;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        probe = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [15:0] ain [3] = '{16'h0, 16'h0, 16'h0};
    logic [6:0]  req_bits = 7'h0;
    logic [6:0]  bits;
    logic [6:0]  flags;
    logic signed [15:0] req_cmd = 16'sh0, req_fb = 16'sh0, cmd, fb, cmd_out;
    logic [15:0] fwd_lim, rev_lim;
    logic        lock, pos_b, neg_b;
    int          n_errors = 0;
    int          checked = 0;
    note_t       q [$];
    always #10 hclk = ~hclk;
    motion_ctrl_model ctrl_u (.hclk, .req_bits, .req_cmd, .req_fb, .bits, .cmd, .fb);
    speed_aux dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .analog_in_1(ain[0]), .analog_in_2(ain[1]), .analog_in_3(ain[2]),
        .speed_cmd_in(cmd), .speed_feedback(fb),
        .pos_speed_limit_select_b(bits[0]), .neg_speed_limit_select_b(bits[1]),
        .jog_forward_in(bits[2]), .jog_reverse_in(bits[3]), .command_invert_in(bits[4]),
        .speed_hold_in(bits[5]), .lock_enable_in(bits[6]), .speed_cmd_out(cmd_out),
        .lock_active(lock), .fwd_torque_limit(fwd_lim), .rev_torque_limit(rev_lim),
        .pos_speed_use_b(pos_b), .neg_speed_use_b(neg_b), .coincidence_flag(flags[0]),
        .arrival_flag(flags[1]), .standstill_flag(flags[2]), .speeding_flag(flags[3]),
        .slowing_flag(flags[4]), .fwd_rotation_flag(flags[5]), .rev_rotation_flag(flags[6]));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Counts: %0d compared, %0d mismatched", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // The master never counts cycles; only the watchdog ends a stuck wait.
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        rd     <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd     <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        q.push_back({4'h0, e});
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic note(input logic [3:0] s, input logic [31:0] e);
        q.push_back({s, e});
        probe <= 1'b1;
        @(posedge hclk);
        probe <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic drive(input logic [6:0] b, input int c, input int f, input int n);
        req_bits <= b;
        req_cmd  <= 16'(c);
        req_fb   <= 16'(f);
        repeat (n) @(posedge hclk);
    endtask
    function automatic logic [31:0] pick(input logic [3:0] s);
        case (s)
            4'h1: return {16'h0, fwd_lim};
            4'h2: return {16'h0, rev_lim};
            4'h3: return 32'(cmd_out);
            4'h4: return {25'h0, flags};
            4'h5: return {29'h0, lock, pos_b, neg_b};
            default: return hrdata;
        endcase
    endfunction
    always @(posedge hclk)
    begin
        note_t nt;
        if ((rd && hreadyout === 1'b1) || probe)
        begin
            nt = q.pop_front();
            check(pick(nt.sel), nt.v);
        end
    end
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
    initial
    begin
        int a;
        logic [6:0] cb [6] = '{7'h00, 7'h10, 7'h04, 7'h18, 7'h0c, 7'h21};
        int ce [6] = '{100, -100, 120, -120, 100, 0};
        int fv [3] = '{2000, -2000, 0};
        logic [6:0] fe [3] = '{7'h23, 7'h43, 7'h05};
        void'($urandom(33));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(OFS_TQ_METHOD, 32'h0);
        rdchk(OFS_FWD_A_VAL, {16'h0, RST_LIMIT_VAL});
        rdchk(OFS_LOCK_THR, {16'h0, RST_LOCK_THR});
        rdchk(12'h0fc, 32'h0);
        $display("Test reset values finished");
        bus(OFS_TQ_METHOD, 1'b1, 32'h1);
        bus(OFS_FWD_A_VAL, 1'b1, 32'd800);
        bus(OFS_FWD_B_VAL, 1'b1, 32'd1200);
        drive(7'h03, 0, 0, 3);
        note(4'h5, 32'h3);
        for (int s = 0; s < 4; s++)
        begin
            bus(OFS_POS_TQ_SEL, 1'b1, 32'(s));
            repeat (2) @(posedge hclk);
            note(4'h1, (s == 0 || s == 3) ? 32'd800 : 32'd1200);
        end
        bus(OFS_POS_TQ_SEL, 1'b1, 32'(SEL_SWITCH));
        drive(7'h00, 0, 0, 3);
        note(4'h1, 32'd800);
        bus(OFS_POS_TQ_SEL, 1'b1, 32'(SEL_A));
        for (int s = 1; s < 4; s++)
        begin
            a = $urandom_range(3000);
            ain[s-1] <= 16'(a);
            bus(OFS_FWD_A_SRC, 1'b1, 32'(s));
            repeat (2) @(posedge hclk);
            note(4'h1, 32'(a));
        end
        bus(OFS_REV_TQ_SEL, 1'b1, 32'(SEL_BOTH));
        bus(OFS_REV_A_VAL, 1'b1, 32'd300);
        bus(OFS_REV_B_SRC, 1'b1, 32'(SRC_AIN3));
        repeat (2) @(posedge hclk);
        note(4'h2, (a < 300) ? 32'(a) : 32'd300);
        bus(OFS_TQ_METHOD, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        note(4'h2, 32'(a));
        bus(OFS_FWD_A_SRC, 1'b1, 32'(SRC_SET));
        bus(OFS_FWD_A_VAL, 1'b1, 32'hffff);
        repeat (2) @(posedge hclk);
        note(4'h1, {16'h0, LIMIT_MAX});
        $display("Test torque limits finished");
        foreach (cb[i])
        begin
            drive(cb[i], 100, 0, 4);
            note(4'h3, 32'(ce[i]));
        end
        $display("Test command shaping finished");
        drive(7'h40, -5, 0, 4);
        note(4'h5, 32'h4);
        note(4'h3, 32'h0);
        drive(7'h40, 6, 0, 4);
        note(4'h5, 32'h0);
        note(4'h3, 32'd6);
        drive(7'h00, 5, 0, 4);
        note(4'h5, 32'h0);
        $display("Test position lock finished");
        foreach (fv[i])
        begin
            drive(7'h00, fv[i], fv[i], 300);
            note(4'h4, {25'h0, fe[i]});
        end
        // A step of 2000 rpm moves the filtered speed by about 500 in the first tick only.
        drive(7'h00, 0, 2000, 3);
        note(4'h4, 32'h28);
        drive(7'h00, 0, 2000, 100);
        drive(7'h00, 0, 0, 3);
        note(4'h4, 32'h32);
        $display("Test speed flags finished");
        conclude();
    end
endmodule // tb_servo_speed_mode_aux
`default_nettype wire
